/* logic/motor_status_pkg.sv */
package motor_status_pkg;

	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int TALLY_W = 16;
	localparam logic [ADDR_W-1:0] OFS_FAULT_SUMMARY = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_SPEED = 8'h01;
	localparam logic [ADDR_W-1:0] OFS_TALLY_LOW = 8'h02;
	localparam logic [ADDR_W-1:0] OFS_TALLY_HIGH = 8'h03;
	localparam logic [ADDR_W-1:0] OFS_VOLTAGE = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_CURRENT = 8'h05;

	// ************************************************************
	// Field positions and values
	// ************************************************************
	localparam int BIT_SUMMARY = 7;
	localparam int BIT_RSVD = 6;
	localparam int BIT_STALL = 5;
	localparam int BIT_OVERCURRENT = 4;
	localparam int BIT_OVERVOLTAGE = 3;
	localparam int BIT_THERMAL = 2;
	localparam int BIT_POWER_ON = 1;
	localparam int BIT_COUNT_DONE = 0;
	localparam int TALLY_LOW_LSB = 0;
	localparam int TALLY_HIGH_LSB = 8;
	localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
	localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;
	localparam logic [TALLY_W-1:0] TALLY_ZERO = 16'h0000;
	localparam logic [TALLY_W-1:0] TALLY_MAX = 16'hFFFF;
	localparam logic [TALLY_W-1:0] TALLY_ONE = 16'h0001;
	localparam logic [DATA_W-1:0] VOLT_CODE_11V = 8'hB0;
	localparam logic [DATA_W-1:0] CURR_CODE_FULL = 8'hC0;
	localparam int SYNC_IN_W = 5;

	// ************************************************************
	// Carriers
	// ************************************************************
	typedef struct packed {
		logic stall;
		logic overcurrent;
		logic overvoltage;
		logic thermal;
	} fault_det_t;

	typedef struct packed {
		logic [DATA_W-1:0] speed;
		logic [DATA_W-1:0] terminal_voltage_code;
		logic [DATA_W-1:0] motor_current_code;
	} readings_t;

	typedef struct packed {
		logic stall_flag;
		logic overcurrent_flag;
		logic overvoltage_flag;
		logic thermal_shutdown_flag;
		logic power_on_indicator;
		logic count_reached_flag;
		logic [TALLY_W-1:0] ripple_tally;
		readings_t readings;
		logic clear_faults_bit;
		logic clear_tally_bit;
		logic [DATA_W-1:0] rd_data;
		logic rd_valid;
		logic pin_drive;
	} status_state_t;

endpackage

/* logic/in_sync3.sv */
module in_sync3 #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Asynchronous levels in, filtered levels out
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	// ************************************************************
	// Three stage synchroniser with agreement filter
	// ************************************************************
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] q;
	} sync_state_t;

	sync_state_t st_r;
	sync_state_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = async_in;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (st_r.s2[i] == st_r.s3[i]) begin
				st_nxt.q[i] = st_r.s3[i];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sync_out = st_r.q;

endmodule

/* logic/motor_driver_status_bank.sv */
// Functional notes
// - Summary bit high while any fault active.
// - Fault pin pulled low while summary set.
// - Stall bit set on detected motor stall.
// - Overcurrent bit set on overcurrent event.
// - Overvoltage bit set on overvoltage event.
// - Thermal bit set on thermal shutdown event.
// - Power-on indicator low from reset until clear.
// - Power-on indicator latches high on fault clear.
// - Count-done latches when tally exceeds threshold.
// - Count-done cleared only by clear-count command.
// - Speed estimate readable as eight-bit value.
// - Sixteen-bit tally, low byte at offset 2.
// - Tally high byte at offset 3.
// - Terminal voltage code, B0h equals eleven volts.
// - Current code, C0h equals selected full scale.
// - Status registers read-only, zero after reset.
// - Clear-fault bit clears latches, self-clears.
// - Clear-count zeroes tally, flag, self-clears.
module motor_driver_status_bank #(
	parameter int TALLY_W = motor_status_pkg::TALLY_W
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Fault detector levels from the analog protection circuits
	input wire motor_status_pkg::fault_det_t fault_det,
	// Ripple counting logic on the same clock
	input wire logic ripple_pulse,
	input wire logic [TALLY_W-1:0] count_threshold,
	// Measurement codes on the same clock
	input wire motor_status_pkg::readings_t readings_in,
	// Control bit writes from the host interface
	input wire logic clear_faults_cmd,
	input wire logic clear_tally_cmd,
	// Register read port from the host interface
	input wire logic rd_req,
	input wire logic [motor_status_pkg::ADDR_W-1:0] rd_addr,
	output logic [motor_status_pkg::DATA_W-1:0] rd_data,
	output logic rd_valid,
	// Control bit readback
	output logic clear_faults_bit,
	output logic clear_tally_bit,
	// Open drain fault pin
	input wire logic fault_out_pin_n_i,
	output logic fault_out_pin_n_o,
	output logic fault_out_pin_n_oe,
	output logic fault_pin_low_seen,
	// Direct status view
	output logic [motor_status_pkg::DATA_W-1:0] fault_summary_status,
	output logic [TALLY_W-1:0] ripple_tally
);

	// ************************************************************
	// Fault byte assembly
	// ************************************************************
	// Summary of the reported fault flags, shared by the byte and the pin.
	function automatic logic summary_of(
		input motor_status_pkg::status_state_t s
	);
		return s.stall_flag | s.overcurrent_flag | s.overvoltage_flag
			| s.thermal_shutdown_flag;
	endfunction

	// Builds the fault status byte from the latched flags of one state copy.
	function automatic logic [motor_status_pkg::DATA_W-1:0] fault_byte(
		input motor_status_pkg::status_state_t s
	);
		logic [motor_status_pkg::DATA_W-1:0] b;
		b = motor_status_pkg::STATUS_RESET;
		b[motor_status_pkg::BIT_SUMMARY] = summary_of(s);
		b[motor_status_pkg::BIT_RSVD] = 1'b0;
		b[motor_status_pkg::BIT_STALL] = s.stall_flag;
		b[motor_status_pkg::BIT_OVERCURRENT] = s.overcurrent_flag;
		b[motor_status_pkg::BIT_OVERVOLTAGE] = s.overvoltage_flag;
		b[motor_status_pkg::BIT_THERMAL] = s.thermal_shutdown_flag;
		b[motor_status_pkg::BIT_POWER_ON] = s.power_on_indicator;
		b[motor_status_pkg::BIT_COUNT_DONE] = s.count_reached_flag;
		return b;
	endfunction

	// ************************************************************
	// Latch and counter helpers
	// ************************************************************
	// A set request wins over a clear in the same cycle.
	function automatic logic latch_flag(
		input logic cur,
		input logic set,
		input logic clr
	);
		return set | (cur & ~clr);
	endfunction

	function automatic logic [TALLY_W-1:0] tally_step(
		input logic [TALLY_W-1:0] cur
	);
		logic [TALLY_W-1:0] r;
		r = cur;
		if (cur != TALLY_W'(motor_status_pkg::TALLY_MAX)) begin
			r = cur + TALLY_W'(motor_status_pkg::TALLY_ONE);
		end
		return r;
	endfunction

	// Reports whether a tally has passed the programmed threshold.
	function automatic logic count_exceeds(
		input logic [TALLY_W-1:0] tally,
		input logic [TALLY_W-1:0] limit
	);
		return tally > limit;
	endfunction

	// Picks one byte of the ripple tally.
	function automatic logic [motor_status_pkg::DATA_W-1:0] tally_byte(
		input logic [TALLY_W-1:0] tally,
		input int lsb
	);
		return tally[lsb +: motor_status_pkg::DATA_W];
	endfunction

	// ************************************************************
	// Read decode
	// ************************************************************
	// Selects the byte at one offset, unmapped offsets read as zero.
	function automatic logic [motor_status_pkg::DATA_W-1:0] read_word(
		input motor_status_pkg::status_state_t s,
		input logic [motor_status_pkg::ADDR_W-1:0] addr
	);
		logic [motor_status_pkg::DATA_W-1:0] w;
		w = motor_status_pkg::UNMAPPED_READ;
		unique case (addr)
			motor_status_pkg::OFS_FAULT_SUMMARY: begin
				w = fault_byte(s);
			end
			motor_status_pkg::OFS_SPEED: begin
				w = s.readings.speed;
			end
			motor_status_pkg::OFS_TALLY_LOW: begin
				w = tally_byte(s.ripple_tally, motor_status_pkg::TALLY_LOW_LSB);
			end
			motor_status_pkg::OFS_TALLY_HIGH: begin
				w = tally_byte(s.ripple_tally, motor_status_pkg::TALLY_HIGH_LSB);
			end
			motor_status_pkg::OFS_VOLTAGE: begin
				w = s.readings.terminal_voltage_code;
			end
			motor_status_pkg::OFS_CURRENT: begin
				w = s.readings.motor_current_code;
			end
			default: begin
				w = motor_status_pkg::UNMAPPED_READ;
			end
		endcase
		return w;
	endfunction

	// ************************************************************
	// Input synchronisation
	// ************************************************************
	logic [motor_status_pkg::SYNC_IN_W-1:0] raw_in;
	logic [motor_status_pkg::SYNC_IN_W-1:0] sync_in;
	motor_status_pkg::fault_det_t det_s;
	logic pin_low_s;

	// Fault levels and the pin readback share one synchroniser.
	logic pin_low_raw;
	assign pin_low_raw = ~fault_out_pin_n_i;
	assign raw_in = {fault_det, pin_low_raw};

	in_sync3 #(
		.WIDTH(motor_status_pkg::SYNC_IN_W)
	) u_sync (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.async_in(raw_in),
		.sync_out(sync_in)
	);

	assign det_s = sync_in[motor_status_pkg::SYNC_IN_W-1:1];
	assign pin_low_s = sync_in[0];

	// ************************************************************
	// State
	// ************************************************************
	motor_status_pkg::status_state_t st_r;
	motor_status_pkg::status_state_t st_nxt;
	// Working values of the next-state logic.
	logic [TALLY_W-1:0] tally_next;
	logic count_over;
	logic do_clear_faults;
	logic do_clear_tally;

	// ************************************************************
	// Control strobes
	// ************************************************************
	// The control bits act one cycle after the host strobe.
	assign do_clear_faults = st_r.clear_faults_bit;
	assign do_clear_tally = st_r.clear_tally_bit;

	always_comb begin
		st_nxt = st_r;
		tally_next = st_r.ripple_tally;
		count_over = 1'b0;

		// ************************************************************
		// Control bits
		// ************************************************************
		// Self-clearing control bits act for one cycle, then return to zero.
		st_nxt.clear_faults_bit = clear_faults_cmd;
		st_nxt.clear_tally_bit = clear_tally_cmd;

		// ************************************************************
		// Fault latches
		// ************************************************************
		// Latched faults, a new detection wins over a clear in the same cycle.
		st_nxt.stall_flag = latch_flag(st_r.stall_flag, det_s.stall,
			do_clear_faults);
		st_nxt.overcurrent_flag = latch_flag(st_r.overcurrent_flag,
			det_s.overcurrent, do_clear_faults);
		st_nxt.overvoltage_flag = latch_flag(st_r.overvoltage_flag,
			det_s.overvoltage, do_clear_faults);
		st_nxt.thermal_shutdown_flag = latch_flag(st_r.thermal_shutdown_flag,
			det_s.thermal, do_clear_faults);

		// Power-on indicator stays low until the first clear, then holds high.
		if (do_clear_faults) begin
			st_nxt.power_on_indicator = 1'b1;
		end

		// ************************************************************
		// Ripple tally
		// ************************************************************
		// Ripple tally, saturating, zeroed by the clear-count command.
		if (do_clear_tally) begin
			tally_next = TALLY_W'(motor_status_pkg::TALLY_ZERO);
		end else if (ripple_pulse) begin
			tally_next = tally_step(st_r.ripple_tally);
		end
		st_nxt.ripple_tally = tally_next;

		// Count-done: set wins over clear, only clear-count removes it.
		count_over = count_exceeds(tally_next, count_threshold);
		st_nxt.count_reached_flag = latch_flag(st_r.count_reached_flag,
			count_over, do_clear_tally);

		// ************************************************************
		// Measurements
		// ************************************************************
		// Measurement codes pass straight through into read-only registers.
		st_nxt.readings = readings_in;

		// ************************************************************
		// Fault pin
		// ************************************************************
		// Fault pin follows the summary bit.
		st_nxt.pin_drive = summary_of(st_nxt);

		// ************************************************************
		// Read port
		// ************************************************************
		// One cycle latency, data holds until the next read.
		st_nxt.rd_valid = rd_req;
		if (rd_req) begin
			st_nxt.rd_data = read_word(st_r, rd_addr);
		end
	end

	// ************************************************************
	// Registers
	// ************************************************************
	// Reset clears every register, so each status byte reads zero.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ************************************************************
	// Read port outputs
	// ************************************************************
	assign rd_data = st_r.rd_data;
	assign rd_valid = st_r.rd_valid;

	// ************************************************************
	// Control bit readback
	// ************************************************************
	assign clear_faults_bit = st_r.clear_faults_bit;
	assign clear_tally_bit = st_r.clear_tally_bit;

	// ************************************************************
	// Fault pin
	// ************************************************************
	// The pin is only ever pulled low, the pull-up gives the released level.
	assign fault_out_pin_n_o = 1'b0;
	assign fault_out_pin_n_oe = st_r.pin_drive;
	assign fault_pin_low_seen = pin_low_s;

	// ************************************************************
	// Status view
	// ************************************************************
	assign fault_summary_status = fault_byte(st_r);
	assign ripple_tally = st_r.ripple_tally;

endmodule

/* bench/motor_driver_status_bank_properties.sv */
module motor_status_checker #(
	parameter int TALLY_W = motor_status_pkg::TALLY_W
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Watched ports
	input wire logic ripple_pulse,
	input wire logic [TALLY_W-1:0] count_threshold,
	input wire logic clear_faults_cmd,
	input wire logic clear_tally_cmd,
	input wire logic rd_req,
	input wire logic rd_valid,
	input wire logic clear_faults_bit,
	input wire logic clear_tally_bit,
	input wire logic fault_out_pin_n_oe,
	input wire logic [motor_status_pkg::DATA_W-1:0] fault_summary_status,
	input wire logic [TALLY_W-1:0] ripple_tally
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	summary_pin_a: assert property (fault_out_pin_n_oe == fault_summary_status[7])
		else $error("fault pin enable differs from summary bit");
	summary_or_a: assert property (fault_summary_status[7] == |fault_summary_status[5:2])
		else $error("summary bit is not the OR of the flags");
	reserved_zero_a: assert property (!fault_summary_status[6])
		else $error("reserved fault bit set");
	read_latency_a: assert property (rd_valid == $past(rd_req))
		else $error("read answer not one cycle after request");
	clear_fault_a: assert property (clear_faults_cmd |=> clear_faults_bit ##1
		(!clear_faults_bit && fault_summary_status[1]))
		else $error("clear fault sequence wrong");
	clear_tally_a: assert property (clear_tally_cmd |=> clear_tally_bit ##1
		(!clear_tally_bit && ripple_tally == '0 && !fault_summary_status[0]))
		else $error("clear count sequence wrong");
	tally_step_a: assert property (ripple_pulse && !clear_tally_bit && ripple_tally != '1
		|=> ripple_tally == $past(ripple_tally) + 1'b1)
		else $error("tally did not advance by one");
	count_set_a: assert property ((ripple_tally > count_threshold) && !clear_tally_bit
		|-> fault_summary_status[0])
		else $error("count flag missing above threshold");
	count_hold_a: assert property ($fell(fault_summary_status[0]) |-> $past(clear_tally_bit))
		else $error("count flag dropped without clear");
	power_on_a: assert property ($rose(fault_summary_status[1]) |-> $past(clear_faults_bit))
		else $error("power-on indicator rose without clear");
endmodule

bind motor_driver_status_bank motor_status_checker #(.TALLY_W(TALLY_W)) i_checker (
	.sys_clk, .reset_n, .ripple_pulse, .count_threshold, .clear_faults_cmd, .clear_tally_cmd,
	.rd_req, .rd_valid, .clear_faults_bit, .clear_tally_bit, .fault_out_pin_n_oe,
	.fault_summary_status, .ripple_tally
);

/* bench/host_reader.sv */
module host_reader (
	// Clock
	input wire logic sys_clk,
	// Requests
	output logic rd_req,
	output logic [motor_status_pkg::ADDR_W-1:0] rd_addr,
	output logic clear_faults_cmd,
	output logic clear_tally_cmd,
	// Answers
	input wire logic [motor_status_pkg::DATA_W-1:0] rd_data,
	input wire logic rd_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		rd_req = 1'b0;
		rd_addr = 8'h00;
		clear_faults_cmd = 1'b0;
		clear_tally_cmd = 1'b0;
	end
	// Reads one register and returns the data with the valid flag.
	task automatic read(input logic [7:0] a, output logic [7:0] d, output logic ok);
		@(negedge sys_clk);
		rd_req = 1'b1;
		rd_addr = a;
		@(negedge sys_clk);
		rd_req = 1'b0;
		rd_addr = ~a;
		ok = rd_valid;
		d = rd_data;
	endtask
	// Issues one clear command and waits until it has acted.
	task automatic clear(input logic tally);
		@(negedge sys_clk);
		clear_faults_cmd = !tally;
		clear_tally_cmd = tally;
		@(negedge sys_clk);
		clear_faults_cmd = 1'b0;
		clear_tally_cmd = 1'b0;
		repeat (2) @(negedge sys_clk);
	endtask
endmodule

/* bench/motor_driver_status_bank_test.sv */
module motor_driver_status_bank_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, reset_n, ripple_pulse, rd_req, clear_faults_cmd, clear_tally_cmd, rd_valid;
	logic clear_faults_bit, clear_tally_bit, fault_out_pin_n_o, fault_out_pin_n_oe;
	logic fault_pin_low_seen, ok;
	motor_status_pkg::fault_det_t fault_det;
	motor_status_pkg::readings_t readings_in;
	logic [15:0] count_threshold, ripple_tally;
	logic [7:0] rd_addr, rd_data, fault_summary_status, got;
	wire logic fault_out_pin_n_i = fault_out_pin_n_oe ? fault_out_pin_n_o : 1'b1;
	int bad_count = 0;
	int comparisons = 0;
	int flags, pwr, cnt, tally, thr;
	motor_driver_status_bank i_dut (.sys_clk, .reset_n, .fault_det, .ripple_pulse,
		.count_threshold, .readings_in, .clear_faults_cmd, .clear_tally_cmd, .rd_req, .rd_addr,
		.rd_data, .rd_valid, .clear_faults_bit, .clear_tally_bit, .fault_out_pin_n_i,
		.fault_out_pin_n_o, .fault_out_pin_n_oe, .fault_pin_low_seen, .fault_summary_status,
		.ripple_tally);
	host_reader i_host (.sys_clk, .rd_req, .rd_addr, .clear_faults_cmd, .clear_tally_cmd,
		.rd_data, .rd_valid);
	// ********
	// Model and checks
	// ********
	function automatic logic [7:0] model(input int a);
		case (a)
			0: return {flags != 0, 1'b0, 4'(flags), pwr[0], cnt[0]};
			1: return readings_in.speed;
			2: return 8'(tally);
			3: return 8'(tally >> 8);
			4: return readings_in.terminal_voltage_code;
			5: return readings_in.motor_current_code;
			default: return 8'h00;
		endcase
	endfunction
	task automatic check(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic read_all();
		for (int a = 0; a < 8; a++) begin
			i_host.read(8'(a), got, ok);
			check({7'h00, ok}, 8'h01);
			check(got, model(a));
		end
		check({7'h00, fault_pin_low_seen}, 8'(flags != 0));
		check(fault_summary_status, model(0));
		check(ripple_tally[7:0], model(2));
		check(ripple_tally[15:8], model(3));
	endtask
	task automatic stop_test();
		if (bad_count == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		#200us;
		bad_count++;
		stop_test();
	end
	// ********
	// Main sequence
	// ********
	initial begin
		void'($urandom(32'hb74f_a592));
		reset_n = 1'b0;
		ripple_pulse = 1'b0;
		fault_det = '0;
		readings_in = '0;
		thr = $urandom_range(7, 0);
		count_threshold = 16'(thr);
		flags = 0;
		pwr = 0;
		cnt = 0;
		tally = 0;
		repeat (12) @(negedge sys_clk);
		reset_n = 1'b1;
		read_all();
		for (int i = 0; i < 6; i++) begin
			fault_det = 4'($urandom);
			readings_in = {8'($urandom), i == 1 ? 8'hB0 : 8'($urandom), i == 2 ? 8'hC0 : 8'($urandom)};
			repeat (6) @(negedge sys_clk);
			flags = flags | fault_det;
			for (int p = $urandom_range(9, 4); p > 0; p--) begin
				ripple_pulse = 1'b1;
				@(negedge sys_clk);
				ripple_pulse = 1'b0;
				@(negedge sys_clk);
				tally++;
				cnt = (tally > thr) ? 1 : cnt;
			end
			read_all();
			i_host.clear(i[0]);
			if (i[0]) begin
				tally = 0;
				cnt = 0;
			end else begin
				flags = fault_det;
				pwr = 1;
			end
		end
		read_all();
		stop_test();
	end
endmodule
